// *** rtl/gcl_map.svh ***
// Purpose: Named offsets, field positions, reset values and timing counts.
// Assumes: Processor addresses are 16 bits, data 8 bits.
// Notes:   Definitions only.
`ifndef GCL_MAP_SVH
`define GCL_MAP_SVH
`define GCL_CLK_MHZ          200
`define GCL_PFAIL_DLY_US     10
`define GCL_PFAIL_DLY_CYC    (`GCL_PFAIL_DLY_US * `GCL_CLK_MHZ)
`define GCL_CAP_CHARGE_CYC   16'h0100
`define GCL_CPU_FAST_KHZ     6000
`define GCL_CPU_SLOW_KHZ     750
`define GCL_CPU_FAST_DIV     8'h21
`define GCL_CPU_SLOW_DIV     8'hFF
`define GCL_ADR_EXP_SEL      16'h8400
`define GCL_ADR_CTRL         16'h8800
`define GCL_ADR_BUS_ADDR     16'h9000
`define GCL_ADR_DIVIDER      16'hB000
`define GCL_ADR_ATTEN        16'hC000
`define GCL_ADR_STATUS       16'hF000
`define GCL_ADR_SLOT_MASK    16'hFFF8
`define GCL_RAM_BASE         16'h6000
`define GCL_RAM_END          16'h67FF
`define GCL_ROM_TOP          16'h6000
`define GCL_BLK_LSB          13
`define GCL_BLK_MSB          15
`define GCL_CTL_AM           0
`define GCL_CTL_FM           1
`define GCL_CTL_INT          2
`define GCL_CTL_1K           3
`define GCL_CTL_LODEV        4
`define GCL_CTL_RFOFF        5
`define GCL_ST_OPT           0
`define GCL_ST_LOCAL         1
`define GCL_ST_OVP           7
`define GCL_FORCED_OPCODE    8'h00
`define GCL_LATCH_RST        8'h00
`define GCL_PAD_RST          7'h00
`define GCL_BIN_RST          8'h00
`define GCL_DIV_THRESH       8'h14
`endif

// *** rtl/gcl_pkg.sv ***
// Purpose: Types shared by the control logic files.
// Assumes: Constants live in gcl_map.svh.
// Notes:   Types only.
package gcl_pkg;
    typedef enum logic [1:0] {
        GCL_PWR_OFF,
        GCL_PWR_CHARGE,
        GCL_PWR_RUN,
        GCL_PWR_FAIL
    } gcl_pwr_t;
    typedef enum logic [1:0] {
        GCL_GAIN_HALF,
        GCL_GAIN_UNITY,
        GCL_GAIN_QUARTER
    } gcl_gain_t;
endpackage : gcl_pkg

// *** rtl/gcl_rst_seq.sv ***
// Purpose: Power-on and power-fail reset sequencing of the processor.
// Assumes: supply_ok_i is the supply comparator output, high above 4.8 V.
// Notes:   Trap is raised on supply loss; reset follows after 10 us.
`timescale 1ns/1ps
`include "gcl_map.svh"
module gcl_rst_seq (
    input  wire logic  clk_i,
    input  wire logic  nrst_i,
    input  wire logic  supply_ok_i,
    output logic       cpu_nrst_o,
    output logic       trap_o
);
    import gcl_pkg::*;
    typedef struct packed {
        gcl_pwr_t    st;
        logic [15:0] cnt;
        logic        nrst;
        logic        trap;
    } gcl_rs_t;
    gcl_rs_t s_q;
    gcl_rs_t s_d;
    localparam logic [15:0] FAIL_CYC = 16'(`GCL_PFAIL_DLY_CYC);

    // Next-state logic of the reset sequencer.
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            GCL_PWR_OFF: begin
                s_d.nrst = 1'b0;
                s_d.trap = 1'b0;
                s_d.cnt  = '0;
                if (supply_ok_i) begin
                    s_d.st = GCL_PWR_CHARGE;
                end
            end
            GCL_PWR_CHARGE: begin
                if (!supply_ok_i) begin
                    s_d.st = GCL_PWR_OFF;
                end else if (s_q.cnt == `GCL_CAP_CHARGE_CYC) begin
                    s_d.st   = GCL_PWR_RUN;
                    s_d.nrst = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                end
            end
            GCL_PWR_RUN: begin
                if (!supply_ok_i) begin
                    s_d.st   = GCL_PWR_FAIL;
                    s_d.trap = 1'b1;
                    s_d.cnt  = '0;
                end
            end
            GCL_PWR_FAIL: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (s_q.cnt == FAIL_CYC - 16'h0001) begin
                    s_d.st   = GCL_PWR_OFF;
                    s_d.nrst = 1'b0;
                end
            end
            default: begin
                s_d.st = GCL_PWR_OFF;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{st: GCL_PWR_OFF, cnt: '0, nrst: 1'b0, trap: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_nrst_o = s_q.nrst;
    assign trap_o     = s_q.trap;
endmodule : gcl_rst_seq

// *** rtl/gcl_switch_ctl.sv ***
// Purpose: Combines mode bits into analog switch controls.
// Assumes: ctrl_i is the registered control latch; div2_i, dbl_i and upper_sb_i come straight from top inputs.
// Notes:   All outputs are registered.
`timescale 1ns/1ps
`include "gcl_map.svh"
module gcl_switch_ctl (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic [7:0]        ctrl_i,
    input  wire logic              div2_i,
    input  wire logic              dbl_i,
    input  wire logic              upper_sb_i,
    output logic                   mod_in_sw_o,
    output logic                   lvl_mod_sw_o,
    output logic                   dev_out_sw_o,
    output gcl_pkg::gcl_gain_t     dev_gain_o,
    output logic                   invert_o
);
    import gcl_pkg::*;
    typedef struct packed {
        logic      mod_in;
        logic      lvl;
        logic      dev;
        gcl_gain_t gain;
        logic      inv;
    } gcl_sw_t;
    gcl_sw_t s_q;
    gcl_sw_t s_d;
    logic    cw;

    // Switch combining; CW mode opens all three switch sets.
    always_comb begin
        cw       = !ctrl_i[`GCL_CTL_AM] && !ctrl_i[`GCL_CTL_FM];
        s_d.mod_in = !cw;
        s_d.lvl    = !cw;
        s_d.dev    = !cw && ctrl_i[`GCL_CTL_FM];
        if (div2_i) begin
            s_d.gain = GCL_GAIN_UNITY;
        end else if (dbl_i) begin
            s_d.gain = GCL_GAIN_QUARTER;
        end else begin
            s_d.gain = GCL_GAIN_HALF;
        end
        s_d.inv = upper_sb_i;
    end

    // Output register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{mod_in: 1'b0, lvl: 1'b0, dev: 1'b0,
                     gain: GCL_GAIN_HALF, inv: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign mod_in_sw_o  = s_q.mod_in;
    assign lvl_mod_sw_o = s_q.lvl;
    assign dev_out_sw_o = s_q.dev;
    assign dev_gain_o   = s_q.gain;
    assign invert_o     = s_q.inv;
endmodule : gcl_switch_ctl

// *** rtl/gcl_top.sv ***
// Purpose: Processor board control logic and modulation switching.
// Assumes: Bus strobes are synchronous to clk_i and active low as named.
// Notes:   Summary of operation follows.
`timescale 1ns/1ps
`include "gcl_map.svh"
module gcl_top (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              supply_ok_i,
    input  wire logic              on_battery_i,
    input  wire logic              rom16k_fitted_i,
    input  wire logic              test_mode_jumper_i,
    input  wire logic              sig_slow_i,
    input  wire logic              ale_i,
    input  wire logic [7:0]        ad_i,
    input  wire logic [7:0]        a_hi_i,
    input  wire logic              rd_n_i,
    input  wire logic              wr_n_i,
    input  wire logic              iom_i,
    input  wire logic [7:0]        ram_rdata_i,
    input  wire logic              panel_irq_i,
    input  wire logic              opt_fitted_i,
    input  wire logic              local_i,
    input  wire logic              ovp_i,
    input  wire logic              sdata_i,
    input  wire logic              sstrobe_i,
    input  wire logic              div2_i,
    input  wire logic              dbl_i,
    input  wire logic              upper_sb_i,
    output logic [7:0]             ad_o,
    output logic                   ad_oe_n_o,
    output logic                   cpu_nrst_o,
    output logic                   trap_o,
    output logic                   panel_interrupt_input_o,
    output logic                   cpu_clk_en_o,
    output logic                   bus_pon_o,
    output logic [7:0]             addr_lo_o,
    output logic [3:0]             mem_sel_n_o,
    output logic                   ram_ce2_n_o,
    output logic [2:0]             exp_cs_n_o,
    output logic [2:0]             filter_o,
    output logic [7:0]             control_line_latch_o,
    output logic [7:0]             divider_setting_o,
    output logic [7:0]             attenuator_setting_o,
    output logic [7:0]             bus_address_o,
    output logic [7:0]             bin_atten_o,
    output logic                   ratio_10_o,
    output logic [6:0]             level_pads_o,
    output logic                   mod_in_sw_o,
    output logic                   lvl_mod_sw_o,
    output logic                   dev_out_sw_o,
    output gcl_pkg::gcl_gain_t     dev_gain_o,
    output logic                   invert_o
);
    import gcl_pkg::*;

    typedef struct packed {
        logic [7:0]  alo;
        logic [7:0]  expsel;
        logic [2:0]  cs_n;
        logic [7:0]  ctrl;
        logic [7:0]  divs;
        logic [7:0]  atts;
        logic [7:0]  baddr;
        logic [7:0]  rdat;
        logic        oe_n;
        logic        irq;
        logic [7:0]  ckcnt;
        logic        cken;
        logic [3:0]  msel_n;
        logic        ce2_n;
        logic        pon;
        logic [15:0] shreg;
        logic [7:0]  bin;
        logic        r10;
        logic [6:0]  pads;
    } gcl_st_t;

    gcl_st_t     s_q;
    gcl_st_t     s_d;
    logic        cpu_nrst;
    logic [15:0] addr;
    logic        wr_stb;
    logic        rd_stb;
    logic [2:0]  blk;
    logic [7:0]  mod_val;
    logic [7:0]  ten_x;
    logic [2:0]  cs_dec;

    // Power sequencing in its own module.
    gcl_rst_seq u_rst (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .supply_ok_i (supply_ok_i),
        .cpu_nrst_o  (cpu_nrst),
        .trap_o      (trap_o)
    );

    // Analog switch combining in its own module.
    gcl_switch_ctl u_sw (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .ctrl_i       (s_q.ctrl),
        .div2_i       (div2_i),
        .dbl_i        (dbl_i),
        .upper_sb_i   (upper_sb_i),
        .mod_in_sw_o  (mod_in_sw_o),
        .lvl_mod_sw_o (lvl_mod_sw_o),
        .dev_out_sw_o (dev_out_sw_o),
        .dev_gain_o   (dev_gain_o),
        .invert_o     (invert_o)
    );

    // Address, strobes and block number for the current cycle.
    always_comb begin
        addr   = {a_hi_i, s_q.alo};
        wr_stb = !wr_n_i && cpu_nrst;
        rd_stb = !rd_n_i && cpu_nrst;
        blk    = addr[`GCL_BLK_MSB:`GCL_BLK_LSB];
    end

    // Next state of all latches, decode and clock divider.
    always_comb begin
        s_d = s_q;
        mod_val = '0;
        ten_x   = '0;
        // Low address byte is latched on the strobe and held.
        if (ale_i) begin
            s_d.alo = ad_i;
        end
        // Clock enable divider, slowed for signature testing.
        s_d.cken = 1'b0;
        if (s_q.ckcnt == (sig_slow_i ? `GCL_CPU_SLOW_DIV
                                     : `GCL_CPU_FAST_DIV)) begin
            s_d.ckcnt = '0;
            s_d.cken  = 1'b1;
        end else begin
            s_d.ckcnt = s_q.ckcnt + 8'h01;
        end
        // Memory decode in 8 KB blocks, merged for the 16 KB part.
        s_d.msel_n = 4'hF;
        if (!iom_i && addr < `GCL_ROM_TOP && cpu_nrst) begin
            if (rom16k_fitted_i && blk[2:1] == 2'b00) begin
                s_d.msel_n[0] = 1'b0;
            end else begin
                s_d.msel_n[blk[1:0]] = 1'b0;
            end
        end
        // RAM blocked by reset, battery or test mode.
        s_d.ce2_n = !cpu_nrst || on_battery_i
                    || test_mode_jumper_i;
        s_d.pon   = !cpu_nrst;
        s_d.irq   = panel_irq_i;
        // Register writes; other slots in a decoded range are ignored.
        if (wr_stb && !test_mode_jumper_i) begin
            if ((addr & `GCL_ADR_SLOT_MASK) == `GCL_ADR_EXP_SEL
                && addr == `GCL_ADR_EXP_SEL) begin
                s_d.expsel = ad_i;
                s_d.cs_n   = cs_dec;
            end
            if (addr == `GCL_ADR_CTRL) begin
                s_d.ctrl = ad_i;
            end
            if (addr == `GCL_ADR_DIVIDER) begin
                s_d.divs = ad_i;
            end
            if (addr == `GCL_ADR_ATTEN) begin
                s_d.atts = ad_i;
            end
            if (addr == `GCL_ADR_BUS_ADDR) begin
                s_d.baddr = ad_i;
            end
        end
        // Read data: forced opcode in test mode, status, else bus not driven.
        s_d.oe_n = 1'b1;
        s_d.rdat = '0;
        if (rd_stb) begin
            if (test_mode_jumper_i) begin
                s_d.oe_n = 1'b0;
                s_d.rdat = `GCL_FORCED_OPCODE;
            end else if (addr == `GCL_ADR_STATUS) begin
                s_d.oe_n = 1'b0;
                s_d.rdat[`GCL_ST_OPT]   = opt_fitted_i;
                s_d.rdat[`GCL_ST_LOCAL] = local_i;
                s_d.rdat[`GCL_ST_OVP]   = ovp_i;
            end
        end
        // Serial expander shifts in words and updates outputs on strobe.
        if (sstrobe_i) begin
            mod_val  = s_q.shreg[15:8];
            ten_x    = 8'((mod_val << 3) + (mod_val << 1));
            s_d.pads = s_q.shreg[6:0];
            if (mod_val < `GCL_DIV_THRESH) begin
                s_d.r10 = 1'b1;
                s_d.bin = ten_x;
            end else begin
                s_d.r10 = 1'b0;
                s_d.bin = mod_val;
            end
        end else begin
            s_d.shreg = {s_q.shreg[14:0], sdata_i};
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{alo: '0, expsel: `GCL_LATCH_RST, ctrl: `GCL_LATCH_RST,
                     divs: `GCL_LATCH_RST, atts: `GCL_LATCH_RST,
                     baddr: `GCL_LATCH_RST, rdat: '0, oe_n: 1'b1, cs_n: '1,
                     irq: 1'b0, ckcnt: '0, cken: 1'b0, msel_n: 4'hF,
                     ce2_n: 1'b1, pon: 1'b1, shreg: '0,
                     bin: `GCL_BIN_RST, r10: 1'b0, pads: `GCL_PAD_RST};
        end else begin
            s_q <= s_d;
        end
    end

    // Expander selects decode from the written word so they leave a register.
    for (genvar i = 0; i < 3; i++) begin : g_cs
        assign cs_dec[i] = !(ad_i[3] && ad_i[1:0] == 2'(i));
    end

    // Filter bits come from bits 4-6 of the select latch.
    assign exp_cs_n_o              = s_q.cs_n;
    assign filter_o                = s_q.expsel[6:4];
    assign ad_o                    = s_q.rdat;
    assign ad_oe_n_o               = s_q.oe_n;
    assign cpu_nrst_o              = cpu_nrst;
    assign panel_interrupt_input_o = s_q.irq;
    assign cpu_clk_en_o            = s_q.cken;
    assign bus_pon_o               = s_q.pon;
    assign addr_lo_o               = s_q.alo;
    assign mem_sel_n_o             = s_q.msel_n;
    assign ram_ce2_n_o             = s_q.ce2_n;
    assign control_line_latch_o    = s_q.ctrl;
    assign divider_setting_o       = s_q.divs;
    assign attenuator_setting_o    = s_q.atts;
    assign bus_address_o           = s_q.baddr;
    assign bin_atten_o             = s_q.bin;
    assign ratio_10_o              = s_q.r10;
    assign level_pads_o            = s_q.pads;
endmodule : gcl_top

// *** testbench/gcl_props.sv ***
// Purpose: Bound checker on the control logic top ports.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   The trap-to-reset delay is counted in helper logic.
`timescale 1ns/1ps
module gcl_props (
    input wire logic               clk_i,
    input wire logic               nrst_i,
    input wire logic               supply_ok_i,
    input wire logic               on_battery_i,
    input wire logic               test_mode_jumper_i,
    input wire logic               ale_i,
    input wire logic [7:0]         ad_i,
    input wire logic [7:0]         a_hi_i,
    input wire logic               wr_n_i,
    input wire logic               panel_irq_i,
    input wire logic               div2_i,
    input wire logic               dbl_i,
    input wire logic               cpu_nrst_o,
    input wire logic               trap_o,
    input wire logic               panel_interrupt_input_o,
    input wire logic               bus_pon_o,
    input wire logic [7:0]         addr_lo_o,
    input wire logic               ram_ce2_n_o,
    input wire logic [7:0]         control_line_latch_o,
    input wire logic               mod_in_sw_o,
    input wire logic               dev_out_sw_o,
    input wire gcl_pkg::gcl_gain_t dev_gain_o
);
    import gcl_pkg::*;
    logic [11:0] dly_q;
    logic        ctl_wr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Flags a write strobe aimed at the control line latch.
    assign ctl_wr = !wr_n_i && {a_hi_i, addr_lo_o} == 16'h8800;

    // Counts cycles from the trap while the processor is still running.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            dly_q <= 12'h000;
        else if (!cpu_nrst_o)
            dly_q <= 12'h000;
        else if ($rose(trap_o) || dly_q != 12'h000)
            dly_q <= dly_q + 12'h001;
    end

    a_trap_loss: assert property (
        $fell(supply_ok_i) && cpu_nrst_o |-> ##[1:2] trap_o)
        else $error("trap not raised after supply loss");
    a_reset_late: assert property (dly_q <= 12'h7D5)
        else $error("reset not reasserted in time after trap");
    a_reset_early: assert property (
        $fell(cpu_nrst_o) |-> dly_q >= 12'h7CB)
        else $error("reset reasserted too early after trap");
    a_reset_blocks: assert property (
        !cpu_nrst_o && !$past(cpu_nrst_o) |-> ram_ce2_n_o && bus_pon_o)
        else $error("reset does not block ram and bus chip");
    a_battery_block: assert property (
        on_battery_i [*3] |-> ram_ce2_n_o)
        else $error("ram enabled while on battery");
    a_irq_route: assert property (
        panel_irq_i [*3] |-> panel_interrupt_input_o)
        else $error("panel request not routed");
    a_ale_capture: assert property (
        ale_i |=> addr_lo_o == $past(ad_i))
        else $error("low address byte not captured");
    a_ctl_write: assert property (
        ctl_wr && cpu_nrst_o && !test_mode_jumper_i
            |=> control_line_latch_o == $past(ad_i))
        else $error("control latch write lost");
    a_ctl_hold: assert property (
        !ctl_wr |=> $stable(control_line_latch_o))
        else $error("control latch changed without a write");
    a_cw_open: assert property (
        (control_line_latch_o[1:0] == 2'h0) [*3]
            |-> !mod_in_sw_o && !dev_out_sw_o)
        else $error("modulation switches closed in carrier mode");
    a_gain_unity: assert property (
        (div2_i && !dbl_i) [*3] |-> dev_gain_o == GCL_GAIN_UNITY)
        else $error("deviation gain not unity with divider");
endmodule : gcl_props

bind gcl_top gcl_props u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .supply_ok_i(supply_ok_i),
    .on_battery_i(on_battery_i), .test_mode_jumper_i(test_mode_jumper_i),
    .ale_i(ale_i), .ad_i(ad_i), .a_hi_i(a_hi_i), .wr_n_i(wr_n_i),
    .panel_irq_i(panel_irq_i), .div2_i(div2_i), .dbl_i(dbl_i),
    .cpu_nrst_o(cpu_nrst_o), .trap_o(trap_o),
    .panel_interrupt_input_o(panel_interrupt_input_o),
    .bus_pon_o(bus_pon_o), .addr_lo_o(addr_lo_o),
    .ram_ce2_n_o(ram_ce2_n_o), .control_line_latch_o(control_line_latch_o),
    .mod_in_sw_o(mod_in_sw_o), .dev_out_sw_o(dev_out_sw_o),
    .dev_gain_o(dev_gain_o));

// *** testbench/gcl_periph_model.sv ***
// Purpose: Processor-side serial source feeding the switch expander.
// Assumes: A bit is taken at each rising edge while the strobe is low.
// Notes:   Idle data toggles so a stale bit never passes for data.
`timescale 1ns/1ps
module gcl_periph_model (
    input  wire logic clk_i,
    output logic      sdata_o,
    output logic      sstrobe_o
);
    logic busy;

    initial begin
        sdata_o = 1'b0;
        sstrobe_o = 1'b0;
        busy = 1'b0;
    end

    // Keeps the idle data line changing every cycle.
    always @(negedge clk_i) begin
        if (!busy)
            sdata_o <= ~sdata_o;
    end

    // Shifts a word out MSB first, then pulses the load strobe.
    task automatic send(input logic [15:0] w);
        busy = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk_i);
            sdata_o <= w[i];
        end
        @(negedge clk_i);
        sstrobe_o <= 1'b1;
        @(negedge clk_i);
        sstrobe_o <= 1'b0;
        busy = 1'b0;
    endtask : send
endmodule : gcl_periph_model

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the control logic top.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Power failure runs last since it resets the processor.
`timescale 1ns/1ps
module tb;
    import gcl_pkg::*;
    logic        clk_i, nrst_i, sup_i, bat_i, jmp_i, slow_i, ale_i;
    logic        rd_n_i, wr_n_i, irq_i, opt_i, loc_i, ovp_i, sdata_i;
    logic        sstb_i, div2_i, dbl_i, usb_i, oe_n_o, cpu_o, trap_o;
    logic        pint_o, clk_en_o, pon_o, ce2_o, ratio_o, inv_o;
    logic        mod_sw_o, dev_sw_o, lvl_o, rom_i;
    logic [3:0]  msel_o;
    logic [7:0]  ad_i, a_hi_i, ad_o, ctl_o, div_o, att_o, bad_o, bin_o;
    logic [7:0]  rd_v, bx;
    logic [2:0]  cs_o, filt_o;
    logic [6:0]  pads_o;
    gcl_gain_t   gain_o;
    int          fail_count, n_compared, cnt;
    logic [15:0] wv[3] = '{16'h1355, 16'h142A, 16'h807F};
    gcl_gain_t   ge[3] = '{GCL_GAIN_UNITY, GCL_GAIN_QUARTER, GCL_GAIN_HALF};
    int          pe[2] = '{34, 256};

    // Free-running 200 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    gcl_top u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .supply_ok_i(sup_i),
        .on_battery_i(bat_i), .rom16k_fitted_i(rom_i),
        .test_mode_jumper_i(jmp_i), .sig_slow_i(slow_i), .ale_i(ale_i),
        .ad_i(ad_i), .a_hi_i(a_hi_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
        .iom_i(1'b0), .ram_rdata_i(8'h00), .panel_irq_i(irq_i),
        .opt_fitted_i(opt_i), .local_i(loc_i), .ovp_i(ovp_i),
        .sdata_i(sdata_i), .sstrobe_i(sstb_i), .div2_i(div2_i),
        .dbl_i(dbl_i), .upper_sb_i(usb_i), .ad_o(ad_o), .ad_oe_n_o(oe_n_o),
        .cpu_nrst_o(cpu_o), .trap_o(trap_o),
        .panel_interrupt_input_o(pint_o), .cpu_clk_en_o(clk_en_o),
        .bus_pon_o(pon_o), .addr_lo_o(), .mem_sel_n_o(msel_o),
        .ram_ce2_n_o(ce2_o), .exp_cs_n_o(cs_o), .filter_o(filt_o),
        .control_line_latch_o(ctl_o), .divider_setting_o(div_o),
        .attenuator_setting_o(att_o), .bus_address_o(bad_o),
        .bin_atten_o(bin_o), .ratio_10_o(ratio_o), .level_pads_o(pads_o),
        .mod_in_sw_o(mod_sw_o), .lvl_mod_sw_o(lvl_o), .dev_out_sw_o(dev_sw_o),
        .dev_gain_o(gain_o), .invert_o(inv_o));

    gcl_periph_model u_per (.clk_i(clk_i), .sdata_o(sdata_i),
                            .sstrobe_o(sstb_i));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic tmo(input int c, input int lim);
        if (c >= lim) begin
            fail_count++;
            $display("BAD t=%0t wait %h limit %h", $time, c, lim);
            end_sim();
        end
    endtask : tmo

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    // Address phase with the strobe, then one data phase.
    task automatic bus(input logic [15:0] a, input logic [7:0] d,
                       input logic wr);
        @(negedge clk_i);
        ale_i = 1'b1;
        a_hi_i = a[15:8];
        ad_i = a[7:0];
        @(negedge clk_i);
        ale_i = 1'b0;
        ad_i = wr ? d : ~a[7:0];
        wr_n_i = !wr;
        rd_n_i = wr;
        @(negedge clk_i);
        if (!wr) @(negedge clk_i);
        rd_v = ad_o;
        bx = {7'h00, oe_n_o};
        wr_n_i = 1'b1;
        rd_n_i = 1'b1;
        @(negedge clk_i);
    endtask : bus

    // Counts cycles between two clock enable pulses.
    task automatic per(output int p);
        p = 0;
        while (clk_en_o !== 1'b1 && p < 600) begin
            @(negedge clk_i);
            p++;
        end
        p = 0;
        do begin
            @(negedge clk_i);
            p++;
        end while (clk_en_o !== 1'b1 && p < 600);
    endtask : per

    // Main sequence.
    initial begin
        {nrst_i, sup_i, bat_i, jmp_i, slow_i, ale_i} = 6'h00;
        {rom_i, irq_i, opt_i, loc_i, ovp_i, div2_i, dbl_i, usb_i} = 8'h80;
        {rd_n_i, wr_n_i, ad_i, a_hi_i} = 18'h30000;
        fail_count = 0;
        n_compared = 0;
        repeat (20) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        chk({4'h0, cpu_o, pon_o, ce2_o, oe_n_o}, 8'h07);
        sup_i = 1'b1;
        cnt = 0;
        while (cpu_o !== 1'b1 && cnt < 600) begin
            @(negedge clk_i);
            cnt++;
        end
        tmo(cnt, 600);
        chk({7'h00, cnt >= 256}, 8'h01);
        done("power-on");
        for (int i = 0; i < 6; i++) begin
            bus(16'h8800, 8'h01 << i, 1'b1);
            chk(ctl_o, 8'h01 << i);
        end
        bus(16'hB000, 8'hA5, 1'b1);
        bus(16'hC000, 8'h39, 1'b1);
        bus(16'h9000, 8'h1E, 1'b1);
        bus(16'h8400, 8'h79, 1'b1);
        bus(16'h8808, 8'hFF, 1'b1);
        bus(16'hA000, 8'hFF, 1'b1);
        bus(16'hA000, 8'h00, 1'b0);
        jmp_i = 1'b1;
        bus(16'h8800, 8'h07, 1'b1);
        {ovp_i, loc_i, opt_i} = 3'h7;
        bus(16'hF000, 8'h00, 1'b0);
        jmp_i = 1'b0;
        chk(rd_v, 8'h00);
        chk(bx, 8'h00);
        chk(div_o, 8'hA5);
        chk(att_o, 8'h39);
        chk(bad_o, 8'h1E);
        chk({2'h0, cs_o, filt_o}, 8'h2F);
        chk(ctl_o, 8'h20);
        done("latches");
        for (int i = 0; i < 2; i++) begin
            {ovp_i, loc_i, opt_i} = i ? 3'b010 : 3'b101;
            bus(16'hF000, 8'h00, 1'b0);
            chk(rd_v & 8'h83, i ? 8'h02 : 8'h81);
            chk(bx, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            rom_i = i[0];
            bus(16'h2000, 8'h00, 1'b0);
            chk({4'h0, msel_o}, i ? 8'h0E : 8'h0D);
        end
        done("status");
        for (int i = 0; i < 2; i++) begin
            bus(16'h8800, i ? 8'h02 : 8'h00, 1'b1);
            repeat (3) @(negedge clk_i);
            chk({5'h00, lvl_o, mod_sw_o, dev_sw_o}, i ? 8'h07 : 8'h00);
        end
        for (int i = 0; i < 3; i++) begin
            {div2_i, dbl_i, usb_i} = 3'b100 >> i;
            repeat (3) @(negedge clk_i);
            chk({5'h00, inv_o, gain_o}, {5'h00, i == 2, ge[i]});
        end
        done("switches");
        for (int i = 0; i < 2; i++) begin
            {bat_i, irq_i} = i ? 2'b00 : 2'b11;
            repeat (3) @(negedge clk_i);
            chk({6'h00, ce2_o, pint_o}, i ? 8'h00 : 8'h03);
        end
        done("levels");
        for (int i = 0; i < 3; i++) begin
            u_per.send(wv[i]);
            repeat (3) @(negedge clk_i);
            bx = wv[i][15:8] < 8'h14 ? wv[i][15:8] * 8'h0A : wv[i][15:8];
            chk(bin_o, bx);
            chk({ratio_o, pads_o}, {wv[i][15:8] < 8'h14, wv[i][6:0]});
        end
        done("serial");
        for (int s = 0; s < 2; s++) begin
            slow_i = s[0];
            per(cnt);
            tmo(cnt, 600);
            chk({7'h00, cnt == pe[s]}, 8'h01);
        end
        done("clock");
        sup_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({7'h00, trap_o}, 8'h01);
        cnt = 0;
        while (cpu_o === 1'b1 && cnt < 2100) begin
            @(negedge clk_i);
            cnt++;
        end
        tmo(cnt, 2100);
        chk({7'h00, cnt > 1990 && cnt < 2010}, 8'h01);
        repeat (2) @(negedge clk_i);
        chk({6'h00, ce2_o, pon_o}, 8'h03);
        done("power-fail");
        end_sim();
    end
endmodule : tb
